// ---- shared/cbp_pkg.sv ----
// Purpose: Shared constants and types for the bus, serial I/O, interrupt port
// Assumes: Single clock, data 16 bits, address 15 bits
// Notes:   Used by both ends and the carrier interface
package cbp_pkg;
    // -------------------------------------------------------------------
    // Widths
    // -------------------------------------------------------------------
    localparam int DATA_W     = 16;
    localparam int ADDR_W     = 15;
    localparam int CODE_W     = 4;
    localparam int SBIT_W     = 12;   // Serial bit address, lines 0..11
    localparam int XOP_W      = 3;    // External code on lines 12..14
    localparam int SBIT_LSB   = 0;    // Bit field sits in low address bits
    localparam int XOP_LSB    = 12;   // External code in top address bits
    localparam int MASK_LSB   = 0;    // Mask field of status bits 0..3
    // -------------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------------
    localparam logic [3:0] CODE_RST = 4'hF;   // Lowest priority code
    localparam logic [3:0] MASK_RST = 4'h0;
    // -------------------------------------------------------------------
    // Operation kinds presented by the core
    // -------------------------------------------------------------------
    typedef enum logic [2:0] {
        CBP_OP_NONE,
        CBP_OP_MREAD,
        CBP_OP_MWRITE,
        CBP_OP_SOUT,     // Load/set-zero/set-one serial output bit
        CBP_OP_SIN,      // Store/test serial input bit
        CBP_OP_XOP       // External instruction code
    } cbp_op_t;
endpackage : cbp_pkg

// ---- shared/cbp_if.sv ----
// Purpose: Pin-level carrier between processor end and external end
// Assumes: Shared serial input is open drain, wired here
// Notes:   Three-stated pins appear as value plus enable (low = driving)
interface cbp_if;
    import cbp_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic              addr_oe_n;
    logic [DATA_W-1:0] data_dev;
    logic              data_dev_oe_n;
    logic [DATA_W-1:0] data_ext;
    logic              data_ext_oe_n;
    logic              data_bus_in_strobe;
    logic              mem_cycle_select_n;
    logic              write_strobe_n;
    logic              ctl_oe_n;
    logic              serial_io_strobe;
    logic              serial_io_out;
    logic              serial_io_in_o;
    logic              serial_io_in_oe_n;
    logic              serial_io_in;
    logic              irq_request_n;
    logic [CODE_W-1:0] irq_level_code;   // [3] is msb, [0] is lsb
    logic              bus_release_ack;
    // Open-drain line floats high when no source pulls it
    assign serial_io_in = serial_io_in_oe_n ? 1'b1 : serial_io_in_o;
    modport dev (output addr, addr_oe_n, data_dev, data_dev_oe_n,
                 data_bus_in_strobe, mem_cycle_select_n, write_strobe_n,
                 ctl_oe_n, serial_io_strobe, serial_io_out,
                 bus_release_ack,
                 input data_ext, serial_io_in, irq_request_n,
                 irq_level_code);
    modport ext (input addr, addr_oe_n, data_dev, data_dev_oe_n,
                 data_bus_in_strobe, mem_cycle_select_n, write_strobe_n,
                 ctl_oe_n, serial_io_strobe, serial_io_out,
                 bus_release_ack, serial_io_in,
                 output data_ext, data_ext_oe_n, serial_io_in_o,
                 serial_io_in_oe_n, irq_request_n, irq_level_code);
endinterface : cbp_if

// ---- core/cbp_dev.sv ----
// Purpose: Processor pin controller for memory, serial I/O and interrupts
// Assumes: Core issues one operation per request; each takes two cycles
// Notes:   Cycle 0 sets up address, cycle 1 strobes; done pulses after
//          Hold is taken only from idle, so a memory cycle always ends
//          before the buses float
//          Interrupt compare uses the code captured one edge earlier
module cbp_dev
    import cbp_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_rst_b,
    input  wire logic              i_ce,
    input  wire logic              i_req,
    input  wire cbp_pkg::cbp_op_t  i_op,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic              i_sout_bit,
    input  wire logic              i_hold,
    input  wire logic              i_instr_end,
    input  wire logic [CODE_W-1:0] i_mask,
    output logic                   o_busy,
    output logic                   o_done,
    output logic [DATA_W-1:0]      o_rdata,
    output logic                   o_sin_bit,
    output logic                   o_irq_take,
    output logic [CODE_W-1:0]      o_irq_code,
    cbp_if.dev                     bus
);
    import cbp_pkg::*;

    // -------------------------------------------------------------------
    // Cycle sequencer
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {
        CBP_S_IDLE,      // Waiting for a request or a hold
        CBP_S_SETUP,     // Address and selects out, no write or serial strobe yet
        CBP_S_STROBE,    // Strobe cycle; read data sampled at its end
        CBP_S_HOLD       // Buses released to another master
    } cbp_state_t;

    // Sequencer registers and their next values
    cbp_state_t        st_r, st_nxt;
    cbp_op_t           op_r, op_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [DATA_W-1:0] wd_r, wd_nxt;
    logic [DATA_W-1:0] rd_r, rd_nxt;
    logic              sob_r, sob_nxt;
    logic              sib_r, sib_nxt;
    logic              done_r, done_nxt;
    logic [CODE_W-1:0] code_r, code_nxt;
    logic              take_r, take_nxt;

    // Next state; hold only entered between cycles, never mid-cycle
    always_comb begin
        st_nxt   = st_r;
        op_nxt   = op_r;
        addr_nxt = addr_r;
        wd_nxt   = wd_r;
        sob_nxt  = sob_r;
        rd_nxt   = rd_r;
        sib_nxt  = sib_r;
        done_nxt = 1'b0;
        unique case (st_r)
            CBP_S_IDLE: begin
                // Hold wins over a request in the same cycle
                if (i_hold) begin
                    st_nxt = CBP_S_HOLD;
                end else if (i_req && i_op != CBP_OP_NONE) begin
                    st_nxt   = CBP_S_SETUP;
                    op_nxt   = i_op;
                    addr_nxt = i_addr;
                    wd_nxt   = i_wdata;
                    sob_nxt  = i_sout_bit;
                end
            end
            CBP_S_SETUP: st_nxt = CBP_S_STROBE;
            CBP_S_STROBE: begin
                // Results taken on the edge that ends the strobe
                st_nxt   = CBP_S_IDLE;
                done_nxt = 1'b1;
                op_nxt   = CBP_OP_NONE;
                if (op_r == CBP_OP_MREAD) begin
                    rd_nxt = bus.data_ext;
                end
                if (op_r == CBP_OP_SIN) begin
                    sib_nxt = bus.serial_io_in;
                end
            end
            // Leave hold only once release is withdrawn
            CBP_S_HOLD: if (!i_hold) st_nxt = CBP_S_IDLE;
        endcase
    end

    // Sequencer registers; frozen while clock enable is low
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_r   <= CBP_S_IDLE;
            op_r   <= CBP_OP_NONE;
            addr_r <= '0;
            wd_r   <= '0;
            sob_r  <= 1'b0;
            rd_r   <= '0;
            sib_r  <= 1'b0;
            done_r <= 1'b0;
        end else if (i_ce) begin
            st_r   <= st_nxt;
            op_r   <= op_nxt;
            addr_r <= addr_nxt;
            wd_r   <= wd_nxt;
            sob_r  <= sob_nxt;
            rd_r   <= rd_nxt;
            sib_r  <= sib_nxt;
            done_r <= done_nxt;
        end
    end

    // -------------------------------------------------------------------
    // Interrupt code capture and compare
    // -------------------------------------------------------------------
    // Code is resampled every cycle the request stays low, so a raised
    // mask is seen at the next boundary without a fresh request
    always_comb begin
        code_nxt = code_r;
        take_nxt = 1'b0;
        if (!bus.irq_request_n) begin
            code_nxt = bus.irq_level_code;
        end
        // Take pulses for one cycle; a held request that keeps passing
        // the compare pulses again at every boundary
        // Code 1 outranks 15; lower number wins
        if (i_instr_end && !bus.irq_request_n
                && code_r <= i_mask) begin
            take_nxt = 1'b1;
        end
    end

    // Code resets to lowest priority so nothing is taken early unless the mask is 15
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            code_r <= CODE_RST;
            take_r <= 1'b0;
        end else if (i_ce) begin
            code_r <= code_nxt;
            take_r <= take_nxt;
        end
    end

    // -------------------------------------------------------------------
    // Pin drive
    // -------------------------------------------------------------------
    // Decoded views of the current operation
    logic is_mem, in_hold;
    assign is_mem  = (op_r == CBP_OP_MREAD) || (op_r == CBP_OP_MWRITE);
    assign in_hold = (st_r == CBP_S_HOLD);

    // Released bus: strobes, address and data all float together
    assign bus.bus_release_ack    = in_hold;
    assign bus.ctl_oe_n           = in_hold;
    assign bus.addr_oe_n          = in_hold;
    // Address holds memory or serial bit address or external code
    assign bus.addr               = addr_r;
    // Select low only while a memory operation owns the address
    assign bus.mem_cycle_select_n = !is_mem;
    // Bus-in strobe spans setup and strobe of a read, low otherwise
    assign bus.data_bus_in_strobe = (op_r == CBP_OP_MREAD);
    // Drivers off while reading or released
    assign bus.data_dev_oe_n      = in_hold
                                    || (op_r == CBP_OP_MREAD);
    assign bus.data_dev           = wd_r;
    // Write strobe only in the strobe cycle, so address and data have
    // had a full setup cycle to settle before memory latches them
    assign bus.write_strobe_n     = !(op_r == CBP_OP_MWRITE
                                      && st_r == CBP_S_STROBE);
    // Strobe for output bits and external codes, after setup cycle;
    // the external end tells codes from bits by the top address lines
    assign bus.serial_io_strobe   = (st_r == CBP_S_STROBE)
                                    && (op_r == CBP_OP_SOUT
                                        || op_r == CBP_OP_XOP);
    assign bus.serial_io_out      = sob_r;

    // Core-side results; all registered except busy
    assign o_busy     = (st_r != CBP_S_IDLE);
    assign o_done     = done_r;
    assign o_rdata    = rd_r;
    assign o_sin_bit  = sib_r;
    assign o_irq_take = take_r;
    assign o_irq_code = code_r;
endmodule : cbp_dev

// ---- core/cbp_ext.sv ----
// Purpose: External memory, serial I/O and interrupt source end
// Assumes: Memory has no wait states; user side holds the memory array
// Notes:   Serial input drives open drain; user presents the bit level
module cbp_ext
    import cbp_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_rst_b,
    input  wire logic              i_ce,
    input  wire logic [DATA_W-1:0] i_rdata,
    input  wire logic              i_sin_level,
    input  wire logic              i_irq,
    input  wire logic [CODE_W-1:0] i_irq_code,
    output logic [ADDR_W-1:0]      o_mem_addr,
    output logic                   o_mem_we,
    output logic [DATA_W-1:0]      o_mem_wdata,
    output logic                   o_sout_valid,
    output logic [SBIT_W-1:0]      o_sout_addr,
    output logic                   o_sout_bit,
    output logic                   o_xop_valid,
    output logic [XOP_W-1:0]       o_xop_code,
    output logic [SBIT_W-1:0]      o_sin_addr,
    cbp_if.ext                     bus
);
    import cbp_pkg::*;

    // -------------------------------------------------------------------
    // Captured pin events
    // -------------------------------------------------------------------
    logic              we_r, we_nxt, sv_r, sv_nxt, xv_r, xv_nxt, sb_r, sb_nxt;
    logic [ADDR_W-1:0] ma_r, ma_nxt;
    logic [DATA_W-1:0] wd_r, wd_nxt;
    logic              strobe_xop;

    // High address bits non-zero mark an external code, else an output bit
    assign strobe_xop = bus.serial_io_strobe
                        && (bus.addr[XOP_LSB +: XOP_W] != '0);

    always_comb begin
        we_nxt = !bus.write_strobe_n && !bus.ctl_oe_n
                 && !bus.mem_cycle_select_n;
        // Serial strobes also latch the address for bit and code outputs
        ma_nxt = (we_nxt || bus.serial_io_strobe) ? bus.addr : ma_r;
        wd_nxt = we_nxt ? bus.data_dev : wd_r;
        sv_nxt = bus.serial_io_strobe && !strobe_xop;
        sb_nxt = sv_nxt ? bus.serial_io_out : sb_r;
        xv_nxt = strobe_xop;
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            we_r <= 1'b0;
            ma_r <= '0;
            wd_r <= '0;
            sv_r <= 1'b0;
            sb_r <= 1'b0;
            xv_r <= 1'b0;
        end else if (i_ce) begin
            we_r <= we_nxt;
            ma_r <= ma_nxt;
            wd_r <= wd_nxt;
            sv_r <= sv_nxt;
            sb_r <= sb_nxt;
            xv_r <= xv_nxt;
        end
    end

    // -------------------------------------------------------------------
    // Pin drive toward the processor
    // -------------------------------------------------------------------
    // Read data offered only during the processor's bus-in window
    assign bus.data_ext          = i_rdata;
    assign bus.data_ext_oe_n     = !(bus.data_bus_in_strobe
                                     && !bus.mem_cycle_select_n);
    // Open drain: pull low for a zero, release for a one
    assign bus.serial_io_in_o    = 1'b0;
    assign bus.serial_io_in_oe_n = i_sin_level;
    // Request held by user until accepted; code msb in bit 3
    assign bus.irq_request_n     = !i_irq;
    assign bus.irq_level_code    = i_irq_code;

    assign o_mem_we     = we_r;
    assign o_mem_addr   = ma_r;
    assign o_mem_wdata  = wd_r;
    assign o_sout_valid = sv_r;
    assign o_sout_bit   = sb_r;
    assign o_sout_addr  = ma_r[SBIT_LSB +: SBIT_W];
    assign o_xop_valid  = xv_r;
    assign o_xop_code   = ma_r[XOP_LSB +: XOP_W];
    assign o_sin_addr   = bus.addr[SBIT_LSB +: SBIT_W];
endmodule : cbp_ext

// ---- tb/cbp_chk.sv ----
// Purpose: Pin-level checks on the carrier between the two ends
// Assumes: One clock, reset active low, enables low while driving
// Notes:   Watches only what the processor end drives
module cbp_chk
    import cbp_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_rst_b,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              addr_oe_n,
    input  wire logic              data_dev_oe_n,
    input  wire logic              data_bus_in_strobe,
    input  wire logic              mem_cycle_select_n,
    input  wire logic              write_strobe_n,
    input  wire logic              ctl_oe_n,
    input  wire logic              serial_io_strobe,
    input  wire logic              bus_release_ack
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    // Bus-in strobe means a memory read with our drivers off
    a_data_bus_in_strobe_read_only: assert property (
        data_bus_in_strobe && !ctl_oe_n |-> !mem_cycle_select_n
            && data_dev_oe_n) else $error("bus-in strobe outside read");
    // Read keeps the strobe for setup and strobe cycles, then drops it
    a_data_bus_in_strobe_two_cycles: assert property (
        $rose(data_bus_in_strobe) |-> data_bus_in_strobe[*2]
            ##1 !data_bus_in_strobe) else $error("bus-in strobe length");
    a_data_bus_in_strobe_low_write: assert property (
        !ctl_oe_n && !write_strobe_n |-> !data_bus_in_strobe)
        else $error("bus-in strobe high during write");
    a_write_with_data: assert property (
        !ctl_oe_n && !write_strobe_n |-> !data_dev_oe_n
            && !mem_cycle_select_n) else $error("write without data");
    a_write_one_cycle: assert property (
        $fell(write_strobe_n) |=> write_strobe_n)
        else $error("write strobe longer than one cycle");
    a_sclk_pulse: assert property (
        $rose(serial_io_strobe) |=> !serial_io_strobe)
        else $error("serial strobe not a pulse");
    // Serial cycles use the address bus without memory select
    a_sclk_io_addr: assert property (
        serial_io_strobe |-> mem_cycle_select_n && !addr_oe_n)
        else $error("serial strobe with memory select");
    // Bus-in strobe stays low whenever no memory address is out
    a_data_bus_in_strobe_low_other: assert property (
        !ctl_oe_n && mem_cycle_select_n |-> !data_bus_in_strobe)
        else $error("bus-in strobe high outside memory cycle");
    // Memory address holds steady for the whole memory cycle
    a_addr_held: assert property (
        !mem_cycle_select_n ##1 !mem_cycle_select_n |-> $stable(addr))
        else $error("address moved during memory cycle");
    a_hold_float: assert property (
        bus_release_ack |-> addr_oe_n && data_dev_oe_n && ctl_oe_n)
        else $error("bus driven while released");
endmodule : cbp_chk

// ---- tb/tb_cbp.sv ----
// Purpose: Self-checking bench joining processor end and external end
// Assumes: Inputs change at falling edge, 25 MHz clock
// Notes:   External user outputs are captured on the rising edge
module tb_cbp;
    timeunit 1ns;
    timeprecision 100ps;
    import cbp_pkg::*;
    logic              clk = 1'b0, i_rst_b = 1'b0, i_req = 1'b0;
    cbp_op_t           i_op = CBP_OP_NONE;
    logic [ADDR_W-1:0] i_addr = '0, o_mem_addr;
    logic [DATA_W-1:0] i_wdata = '0, i_rdata = '0, o_rdata, o_mem_wdata;
    logic              i_sout_bit = 1'b0, i_hold = 1'b0, i_instr_end = 1'b0;
    logic [CODE_W-1:0] i_mask = 4'h0, i_irq_code = 4'hF, o_irq_code;
    logic              i_sin_level = 1'b0, i_irq = 1'b0;
    logic              o_busy, o_done, o_sin_bit, o_irq_take, o_mem_we;
    logic              o_sout_valid, o_sout_bit, o_xop_valid, so_bit;
    logic [SBIT_W-1:0] o_sout_addr, o_sin_addr, so_addr, sin_addr;
    logic [XOP_W-1:0]  o_xop_code, xop_code;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    int                n_errors = 0, n_checks = 0, n_take = 0, n_cyc = 0;
    int                n_ext = 0;
    cbp_if u_cbp_if ();
    cbp_dev u_cbp_dev (.i_clk(clk), .i_rst_b(i_rst_b), .i_ce(1'b1),
        .i_req(i_req), .i_op(i_op), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_sout_bit(i_sout_bit), .i_hold(i_hold), .i_instr_end(i_instr_end),
        .i_mask(i_mask), .o_busy(o_busy), .o_done(o_done),
        .o_rdata(o_rdata), .o_sin_bit(o_sin_bit), .o_irq_take(o_irq_take),
        .o_irq_code(o_irq_code), .bus(u_cbp_if));
    cbp_ext u_cbp_ext (.i_clk(clk), .i_rst_b(i_rst_b), .i_ce(1'b1),
        .i_rdata(i_rdata), .i_sin_level(i_sin_level), .i_irq(i_irq),
        .i_irq_code(i_irq_code), .o_mem_addr(o_mem_addr),
        .o_mem_we(o_mem_we), .o_mem_wdata(o_mem_wdata),
        .o_sout_valid(o_sout_valid), .o_sout_addr(o_sout_addr),
        .o_sout_bit(o_sout_bit), .o_xop_valid(o_xop_valid),
        .o_xop_code(o_xop_code), .o_sin_addr(o_sin_addr), .bus(u_cbp_if));
    cbp_chk u_cbp_chk (.i_clk(clk), .i_rst_b(i_rst_b),
        .addr(u_cbp_if.addr), .addr_oe_n(u_cbp_if.addr_oe_n),
        .data_dev_oe_n(u_cbp_if.data_dev_oe_n),
        .data_bus_in_strobe(u_cbp_if.data_bus_in_strobe),
        .mem_cycle_select_n(u_cbp_if.mem_cycle_select_n),
        .write_strobe_n(u_cbp_if.write_strobe_n),
        .ctl_oe_n(u_cbp_if.ctl_oe_n),
        .serial_io_strobe(u_cbp_if.serial_io_strobe),
        .bus_release_ack(u_cbp_if.bus_release_ack));

    always #20 clk = ~clk;
    // Latch pulsed user outputs so tasks can judge them afterwards
    always @(posedge clk) begin
        if (o_mem_we) begin
            wr_addr <= o_mem_addr;
            wr_data <= o_mem_wdata;
        end
        if (o_sout_valid) {so_addr, so_bit} <= {o_sout_addr, o_sout_bit};
        if (o_xop_valid) xop_code <= o_xop_code;
        if (o_busy) sin_addr <= o_sin_addr;
        if (!u_cbp_if.data_ext_oe_n) n_ext <= n_ext + 1;
        if (o_irq_take) n_take <= n_take + 1;
    end
    // Cycle ceiling guards against a hung handshake
    always @(posedge clk) begin
        n_cyc <= n_cyc + 1;
        if (n_cyc == 5000) begin
            n_errors++;
            test_done();
        end
    end

    task automatic chk(input string nm, input logic [15:0] e, got);
        n_checks++;
        if (got !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, got);
        end
    endtask : chk
    // Issue one core operation and wait for its done pulse
    task automatic run_op(input cbp_op_t op, input logic [14:0] a,
                          input logic [15:0] d, input logic b);
        int n;
        n = 0;
        @(negedge clk);
        {i_req, i_addr, i_wdata, i_sout_bit} = {1'b1, a, d, b};
        i_op = op;
        @(negedge clk);
        i_req = 1'b0;
        i_op = CBP_OP_NONE;
        while (o_done !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        chk("done", 16'h1, 16'(o_done));
        @(negedge clk);
    endtask : run_op
    task automatic t_mem();
        run_op(CBP_OP_MWRITE, 15'h1234, 16'hA5C3, 1'b0);
        chk("wr_addr", 16'h1234, 16'(wr_addr));
        chk("wr_data", 16'hA5C3, wr_data);
        i_rdata = 16'h5A3C;
        run_op(CBP_OP_MREAD, 15'h0456, 16'h0000, 1'b0);
        chk("rdata", 16'h5A3C, o_rdata);
        chk("ext_drive", 16'h2, 16'(n_ext));
    endtask : t_mem
    task automatic t_serial();
        run_op(CBP_OP_SOUT, 15'h0ABC, 16'h0000, 1'b1);
        chk("sout_bit1", 16'h1, 16'(so_bit));
        run_op(CBP_OP_SOUT, 15'h0FFF, 16'h0000, 1'b0);
        chk("sout_bit0", 16'h0, 16'(so_bit));
        chk("sout_addr", 16'h0FFF, 16'(so_addr));
        for (int c = 1; c < 8; c++) begin
            run_op(CBP_OP_XOP, {3'(c), 12'h000}, 16'h0000, 1'b0);
            chk("xop_code", 16'(c), 16'(xop_code));
        end
        for (int v = 0; v < 2; v++) begin
            i_sin_level = v[0];
            run_op(CBP_OP_SIN, 15'h0123, 16'h0000, 1'b0);
            chk("sin_bit", 16'(v), 16'(o_sin_bit));
            chk("sin_addr", 16'h0123, 16'(sin_addr));
        end
    endtask : t_serial
    // Code, mask, accept: boundaries on both sides of the mask
    task automatic t_irq();
        logic [11:0] tbl [6] = '{12'h870, 12'h881, 12'h100, 12'h111,
                                 12'hFE0, 12'hFF1};
        int base;
        foreach (tbl[k]) begin
            @(negedge clk);
            {i_irq_code, i_mask} = tbl[k][11:4];
            i_irq = 1'b1;
            repeat (4) @(negedge clk);
            base = n_take;
            i_instr_end = 1'b1;
            @(negedge clk);
            i_instr_end = 1'b0;
            repeat (4) @(negedge clk);
            chk("irq_take", 16'(tbl[k][0]), 16'(n_take - base));
            chk("irq_code", 16'(tbl[k][11:8]), 16'(o_irq_code));
        end
        // Held request, mask raised: next boundary accepts
        base = n_take;
        {i_irq_code, i_mask} = 8'h97;
        repeat (2) @(negedge clk);
        i_instr_end = 1'b1;
        @(negedge clk);
        i_instr_end = 1'b0;
        repeat (2) @(negedge clk);
        i_mask = 4'h9;
        i_instr_end = 1'b1;
        @(negedge clk);
        i_instr_end = 1'b0;
        repeat (4) @(negedge clk);
        chk("irq_retry", 16'h1, 16'(n_take - base));
        i_irq = 1'b0;
    endtask : t_irq
    task automatic t_hold();
        @(negedge clk);
        {i_hold, i_req} = 2'b11;
        i_op = CBP_OP_MREAD;
        repeat (3) @(negedge clk);
        chk("ack", 16'h1, 16'(u_cbp_if.bus_release_ack));
        chk("oe_n", 16'h7, 16'({u_cbp_if.addr_oe_n,
            u_cbp_if.data_dev_oe_n, u_cbp_if.ctl_oe_n}));
        chk("busy", 16'h1, 16'(o_busy));
        {i_hold, i_req} = 2'b00;
        i_op = CBP_OP_NONE;
        repeat (3) @(negedge clk);
        chk("ack_off", 16'h0, 16'(u_cbp_if.bus_release_ack));
    endtask : t_hold
    task automatic test_done();
        if (n_errors == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (5) @(negedge clk);
        i_rst_b = 1'b1;
        t_mem();
        t_serial();
        t_irq();
        t_hold();
        test_done();
    end
endmodule : tb_cbp
